// ### lcd_ctrl_defines.svh
// offsets, fields, reset values and timing counts of the display controller
//==============================================================
// Operation
//==============================================================
// Operation
// RL1: thirty-three byte registers for the driver
// RL2: up to 48 segments by 4 commons
// RL3: control bit 7 enables the driver
// RL4: sleep_disable stops the driver during sleep
// RL5: pixel write without write_allow sets sticky error
// RL6: clock_source_select picks sysclk/4, timer1 or rc
// RL7: commons_mux_select sets one to four commons
// RL8: waveform_type picks type-B or type-A phase
// RL9: bias_mode picks half or third bias
// RL10: software keeps bias_mode zero in modes 00/11
// RL11: display_active reads back on phase bit 5
// RL12: write_allow reads back on phase bit 4
// RL13: frame prescaler divides baseline by code plus one
// RL14: segment enable turns pin into segment driver
// RL15: pixel bit one shows dark, zero clear
// RL16: postscaler of 32 or 8192 makes baseline; the sysclk source has no /4 stage and counts POST_SYS/4, 2048 hclk cycles
// RL17: writable fields reset zero, bit 4 reads zero
// RL18: status bits read-only, error cleared by zero
`ifndef LCD_CTRL_DEFINES_SVH
`define LCD_CTRL_DEFINES_SVH
//==============================================================
// register byte addresses
//==============================================================
`define OFS_CONTROL 12'h000
`define OFS_PHASE 12'h004
`define OFS_REGULATOR 12'h008
`define OFS_IRQ_STATUS 12'h00c
`define OFS_IRQ_MASK 12'h010
`define OFS_SEG_BASE 12'h040
`define OFS_PIX_BASE 12'h080
`define NUM_SEG_REGS 6
`define NUM_PIX_REGS 24
//==============================================================
// field positions and reset values
//==============================================================
`define BIT_ENABLE 7
`define BIT_SLEEP_DIS 6
`define BIT_WRITE_ERROR_FLAG 5
`define BIT_WFT 7
`define BIT_BIAS 6
`define BIT_ACTIVE 5
`define BIT_WALLOW 4
`define CONTROL_RESET 8'h00
`define PHASE_RESET 8'h00
//==============================================================
// timing
//==============================================================
`define POST_SYS 8192
`define POST_SLOW 32
`define FRAME_BASE_CYC 4
`endif

// ### lcd_ctrl_pkg.sv
// types of the display controller
package lcd_ctrl_pkg;
    typedef struct packed {
        logic display_enable;
        logic sleep_disable;
        logic write_error_flag;
        logic [1:0] clock_source_select;
        logic [1:0] commons_mux_select;
    } control_t;
    typedef struct packed {
        logic waveform_type;
        logic bias_mode;
        logic [3:0] frame_prescale;
    } phase_t;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ
    } bus_state_t;
endpackage

// ### lcd_ctrl.sv
// register front end and timing of the segment display driver
`timescale 1ns/100ps
`include "lcd_ctrl_defines.svh"
module lcd_ctrl
    import lcd_ctrl_pkg::*;
#(
    parameter int NUM_SEGS = 48,
    parameter int NUM_COMS = 4,
    parameter int POST_SYS = `POST_SYS,
    parameter int POST_SLOW = `POST_SLOW
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sleep_req,
    input wire logic timer1_osc_input,
    input wire logic internal_rc_clock,
    output logic [NUM_SEGS-1:0] seg_pin_enable,
    output logic [NUM_SEGS*NUM_COMS-1:0] pixel_map,
    output logic [NUM_COMS-1:0] com_active,
    output logic bias_half,
    output logic waveform_b,
    output logic frame_tick,
    output logic [7:0] regulator_out,
    output logic irq
);
    //==========================================================
    // bus address phase capture
    //==========================================================
    logic wr_ff;
    logic [11:0] addr_ff;
    logic rd_ff;
    logic take;
    assign take = hsel & hready & htrans[1];
    // one wait state on reads so hrdata leaves a flip-flop in time
    assign hreadyout = ~rd_ff;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else begin
            wr_ff <= take & hwrite;
            rd_ff <= take & ~hwrite;
            addr_ff <= haddr[11:0];
        end
    end
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction
    function automatic logic in_range(input logic [11:0] a,
                                      input logic [11:0] b, input int n);
        in_range = (a >= b) && (a < b + 12'(n * 4));
    endfunction
    //==========================================================
    // registers
    //==========================================================
    control_t control_ff;
    phase_t phase_ff;
    logic [7:0] regulator_ff;
    logic [7:0] seg_ff [`NUM_SEG_REGS];
    logic [7:0] pix_ff [`NUM_PIX_REGS];
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic active;
    logic write_allow;
    logic pix_wr;
    logic write_error_flag_set;
    logic [4:0] pix_idx;
    logic [2:0] seg_idx;
    assign pix_idx = 5'((addr_ff - `OFS_PIX_BASE) >> 2);
    assign seg_idx = 3'((addr_ff - `OFS_SEG_BASE) >> 2);
    assign pix_wr = wr_ff & in_range(addr_ff, `OFS_PIX_BASE, `NUM_PIX_REGS);
    assign write_error_flag_set = pix_wr & ~write_allow; // RL5
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_ff <= control_t'(7'h00); // RL17
            phase_ff <= phase_t'(6'h00); // RL17
            regulator_ff <= 8'h00;
        end else begin
            if (wr_ff && hit(addr_ff, `OFS_CONTROL)) begin
                control_ff.display_enable <= hwdata[`BIT_ENABLE];
                control_ff.sleep_disable <= hwdata[`BIT_SLEEP_DIS];
                control_ff.clock_source_select <= hwdata[3:2];
                control_ff.commons_mux_select <= hwdata[1:0];
            end
            if (write_error_flag_set) begin
                control_ff.write_error_flag <= 1'b1; // RL5
            end else if (wr_ff && hit(addr_ff, `OFS_CONTROL) &&
                         !hwdata[`BIT_WRITE_ERROR_FLAG]) begin
                control_ff.write_error_flag <= 1'b0; // RL18
            end
            if (wr_ff && hit(addr_ff, `OFS_PHASE)) begin
                phase_ff.waveform_type <= hwdata[`BIT_WFT];
                phase_ff.bias_mode <= hwdata[`BIT_BIAS];
                phase_ff.frame_prescale <= hwdata[3:0]; // RL18
            end
            if (wr_ff && hit(addr_ff, `OFS_REGULATOR)) begin
                regulator_ff <= hwdata[7:0];
            end
        end
    end
    // RL1
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SEG_REGS; gi++) begin : g_seg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    seg_ff[gi] <= 8'h00;
                end else if (wr_ff && seg_idx == 3'(gi) &&
                        in_range(addr_ff, `OFS_SEG_BASE, `NUM_SEG_REGS)) begin
                    seg_ff[gi] <= hwdata[7:0];
                end
            end
        end
        for (gi = 0; gi < `NUM_PIX_REGS; gi++) begin : g_pix
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pix_ff[gi] <= 8'h00;
                end else if (pix_wr && write_allow && pix_idx == 5'(gi)) begin
                    pix_ff[gi] <= hwdata[7:0];
                end
            end
        end
        // RL14 RL2
        for (gi = 0; gi < NUM_SEGS; gi++) begin : g_segpin
            assign seg_pin_enable[gi] = seg_ff[gi/8][gi%8];
        end
        // RL15: bit one drives the pixel dark
        for (gi = 0; gi < NUM_SEGS*NUM_COMS; gi++) begin : g_pmap
            assign pixel_map[gi] =
                pix_ff[(gi/NUM_SEGS)*6 + (gi%NUM_SEGS)/8][gi%8];
        end
    endgenerate
    //==========================================================
    // clock source, postscaler and frame prescaler
    //==========================================================
    logic t1_d_ff;
    logic rc_d_ff;
    logic src_tick;
    logic [12:0] post_ff;
    logic base_tick;
    logic [3:0] pre_ff;
    logic [1:0] com_ff;
    logic frame_ff;
    logic [12:0] post_lim;
    assign active = control_ff.display_enable &
                    ~(sleep_req & control_ff.sleep_disable); // RL3 RL4
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t1_d_ff <= 1'b0;
            rc_d_ff <= 1'b0;
        end else begin
            t1_d_ff <= timer1_osc_input;
            rc_d_ff <= internal_rc_clock;
        end
    end
    always_comb begin
        // RL6
        case (control_ff.clock_source_select)
            2'b00: src_tick = 1'b1;
            2'b01: src_tick = timer1_osc_input & ~t1_d_ff;
            default: src_tick = internal_rc_clock & ~rc_d_ff;
        endcase
        // RL16
        if (control_ff.clock_source_select == 2'b00) begin
            post_lim = 13'(POST_SYS / `FRAME_BASE_CYC - 1);
        end else begin
            post_lim = 13'(POST_SLOW - 1);
        end
    end
    assign base_tick = src_tick && post_ff >= post_lim;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_ff <= 13'h0000;
        end else if (!active) begin
            post_ff <= 13'h0000;
        end else if (src_tick) begin
            post_ff <= base_tick ? 13'h0000 : post_ff + 13'h0001;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_ff <= 4'h0;
            frame_ff <= 1'b0;
        end else if (!active) begin
            pre_ff <= 4'h0;
            frame_ff <= 1'b0;
        end else begin
            frame_ff <= 1'b0;
            if (base_tick) begin
                if (pre_ff >= phase_ff.frame_prescale) begin // RL13
                    pre_ff <= 4'h0;
                    frame_ff <= 1'b1;
                end else begin
                    pre_ff <= pre_ff + 4'h1;
                end
            end
        end
    end
    // common ring counter wraps at the mux setting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            com_ff <= 2'b00;
        end else if (!active) begin
            com_ff <= 2'b00;
        end else if (frame_ff) begin
            // RL7
            com_ff <= (com_ff >= control_ff.commons_mux_select) ?
                      2'b00 : com_ff + 2'b01;
        end
    end
    always_comb begin
        com_active = '0;
        if (active) begin
            com_active[com_ff] = 1'b1;
        end
    end
    assign frame_tick = frame_ff;
    assign waveform_b = phase_ff.waveform_type; // RL8
    // RL9 RL10
    assign bias_half = phase_ff.bias_mode &
        (control_ff.commons_mux_select == 2'b01 ||
         control_ff.commons_mux_select == 2'b10);
    assign regulator_out = regulator_ff;
    // pixel writes allowed only off the frame boundary
    assign write_allow = ~active | ~frame_ff; // RL12
    //==========================================================
    // interrupts
    //==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
        end else begin
            if (wr_ff && hit(addr_ff, `OFS_IRQ_MASK)) begin
                irq_mask_ff <= hwdata[1:0];
            end
            irq_stat_ff[0] <= frame_ff | (irq_stat_ff[0] &
                ~(wr_ff & hit(addr_ff, `OFS_IRQ_STATUS) & hwdata[0]));
            irq_stat_ff[1] <= write_error_flag_set | (irq_stat_ff[1] &
                ~(wr_ff & hit(addr_ff, `OFS_IRQ_STATUS) & hwdata[1]));
        end
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);
    //==========================================================
    // read data
    //==========================================================
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit(addr_ff, `OFS_CONTROL)) begin
            rd_byte = {control_ff.display_enable, control_ff.sleep_disable,
                       control_ff.write_error_flag, 1'b0, // RL17
                       control_ff.clock_source_select,
                       control_ff.commons_mux_select};
        end else if (hit(addr_ff, `OFS_PHASE)) begin
            rd_byte = {phase_ff.waveform_type, phase_ff.bias_mode,
                       active, write_allow, // RL11 RL12
                       phase_ff.frame_prescale};
        end else if (hit(addr_ff, `OFS_REGULATOR)) begin
            rd_byte = regulator_ff;
        end else if (hit(addr_ff, `OFS_IRQ_STATUS)) begin
            rd_byte = {6'h00, irq_stat_ff};
        end else if (hit(addr_ff, `OFS_IRQ_MASK)) begin
            rd_byte = {6'h00, irq_mask_ff};
        end else if (in_range(addr_ff, `OFS_SEG_BASE, `NUM_SEG_REGS)) begin
            rd_byte = seg_ff[seg_idx];
        end else if (in_range(addr_ff, `OFS_PIX_BASE, `NUM_PIX_REGS)) begin
            rd_byte = pix_ff[pix_idx];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take & ~hwrite) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_ff) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end
endmodule

// ### lcd_ctrl_checker.sv
// bus and timing assertions of the display controller
`timescale 1ns/100ps
`include "lcd_ctrl_defines.svh"
module lcd_ctrl_checker
    import lcd_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sleep_req,
    input wire logic [3:0] com_active,
    input wire logic bias_half,
    input wire logic waveform_b,
    input wire logic frame_tick
);
//==============================================================
// shadow of control and phase
//==============================================================
logic wr_ff;
logic [11:0] adr_ff;
logic [7:0] ctl_ff;
logic [7:0] phs_ff;
logic act;
logic rd_ff;
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rd_ff <= 1'b0;
    end else begin
        rd_ff <= hready & hsel & htrans[1] & !hwrite;
    end
end
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_ff <= 1'b0;
        adr_ff <= 12'h000;
    end else if (hready) begin
        wr_ff <= hsel & htrans[1] & hwrite;
        adr_ff <= haddr[11:0];
    end
end
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctl_ff <= 8'h00;
        phs_ff <= 8'h00;
    end else if (wr_ff && hready) begin
        if (adr_ff == `OFS_CONTROL) ctl_ff <= hwdata[7:0];
        if (adr_ff == `OFS_PHASE) phs_ff <= hwdata[7:0];
    end
end
assign act = ctl_ff[7] & !(sleep_req & ctl_ff[6]);
//==============================================================
// properties
//==============================================================
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
sequence idle_two;
    !act ##1 !act;
endsequence
sequence run_two;
    act ##1 act;
endsequence
sequence asleep_two;
    (sleep_req && ctl_ff[6]) ##1 (sleep_req && ctl_ff[6]);
endsequence
chk_bus_okay: assert property ((hreadyout == !rd_ff) && !hresp)
    else $error("bus answer not okay with one read wait state");
chk_wave_type: assert property (waveform_b == phs_ff[7])
    else $error("waveform output differs from type bit");
chk_bias_half: assert property (bias_half == (phs_ff[6] &&
    (ctl_ff[1:0] == 2'h1 || ctl_ff[1:0] == 2'h2)))
    else $error("bias output wrong for mode");
chk_com_idle: assert property (idle_two |-> com_active == 4'h0)
    else $error("commons driven while disabled");
chk_com_onehot: assert property (run_two |-> $onehot(com_active))
    else $error("commons not one-hot while active");
chk_sleep_stop: assert property (asleep_two |-> com_active == 4'h0)
    else $error("commons driven in sleep");
chk_tick_pulse: assert property (frame_tick |=> !frame_tick)
    else $error("frame tick longer than one cycle");
chk_com_step: assert property (act && frame_tick && ctl_ff[1:0] != 2'h0
    ##1 act |-> com_active != $past(com_active))
    else $error("common did not advance on frame");
endmodule
bind lcd_ctrl lcd_ctrl_checker chk_i (.*);

// ### lcd_glass_panel.sv
// glass panel model: dark segments of the active common
`timescale 1ns/100ps
module lcd_glass_panel #(
    parameter int NUM_SEGS = 48,
    parameter int NUM_COMS = 4
) (
    input wire logic [NUM_SEGS-1:0] seg_pin_enable,
    input wire logic [NUM_SEGS*NUM_COMS-1:0] pixel_map,
    input wire logic [NUM_COMS-1:0] com_active,
    output logic [NUM_SEGS-1:0] dark_row
);
always_comb begin
    dark_row = {NUM_SEGS{1'b0}};
    for (int c = 0; c < NUM_COMS; c++) begin
        if (com_active[c]) begin
            dark_row = pixel_map[c*NUM_SEGS +: NUM_SEGS] & seg_pin_enable;
        end
    end
end
endmodule

// ### lcd_driver_control_regs_bench.sv
// self-checking bench of the display controller
`timescale 1ns/100ps
`include "lcd_ctrl_defines.svh"
module lcd_driver_control_regs_bench
    import lcd_ctrl_pkg::*;
;
logic hclk, hresetn, hsel, hwrite, sleep_req;
logic timer1_osc_input, internal_rc_clock;
logic [31:0] haddr, hwdata, hrdata;
logic [1:0] htrans;
logic [2:0] hsize;
logic hreadyout, hresp, bias_half, waveform_b, frame_tick, irq;
logic [47:0] seg_pin_enable, dark_row;
logic [191:0] pixel_map;
logic [3:0] com_active;
logic [7:0] regulator_out, rnd, q, v;
logic [47:0] row;
int bad_count, tests_run, slow_cnt, gap, p;
lcd_ctrl #(.POST_SYS(64), .POST_SLOW(4)) uut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleep_req(sleep_req), .timer1_osc_input(timer1_osc_input),
    .internal_rc_clock(internal_rc_clock), .seg_pin_enable(seg_pin_enable),
    .pixel_map(pixel_map), .com_active(com_active), .bias_half(bias_half),
    .waveform_b(waveform_b), .frame_tick(frame_tick),
    .regulator_out(regulator_out), .irq(irq));
lcd_glass_panel glass (.seg_pin_enable(seg_pin_enable),
    .pixel_map(pixel_map), .com_active(com_active), .dark_row(dark_row));
//==============================================================
// clocks and helpers
//==============================================================
initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
end
always @(posedge hclk) begin
    slow_cnt <= slow_cnt + 1;
    if (slow_cnt % 3 == 0) internal_rc_clock <= ~internal_rc_clock;
    if (slow_cnt % 5 == 0) timer1_osc_input <= ~timer1_osc_input;
end
function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
endfunction
function int pix_lo(input int n);
    return (n / 6) * 48 + (n % 6) * 8;
endfunction
function int gap_exp(input int cs, input int pre);
    return (cs == 0 ? 16 : (cs == 1 ? 40 : 24)) * (pre + 1);
endfunction
task check(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
        $display("unexpected %s expected %h seen %h", what, exp, got);
        bad_count++;
    end
endtask
task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
task wait_edge(input logic want, input logic which);
    int n;
    n = 0;
    do begin
        @(posedge hclk);
        n++;
    end while ((which ? frame_tick : hreadyout) !== want && n < 3000);
    if (n >= 3000) begin
        bad_count++;
        give_verdict;
    end
endtask
task bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_edge(1'b1, 1'b0);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_edge(1'b1, 1'b0);
    if (!wr) begin
        q = hrdata[7:0];
    end
endtask
task tick_gap;
    wait_edge(1'b1, 1'b1);
    gap = 0;
    do begin
        @(posedge hclk);
        gap++;
    end while (frame_tick !== 1'b1 && gap < 3000);
    if (gap >= 3000) begin
        bad_count++;
        give_verdict;
    end
endtask
//==============================================================
// scenarios
//==============================================================
initial begin
    {hsel, hwrite, sleep_req, timer1_osc_input, internal_rc_clock} = 5'h00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    hresetn = 1'b0;
    rnd = 8'h2d;
    slow_cnt = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `OFS_CONTROL, 8'h00);
    check("control reset", 48'h0, q);
    bus(1'b0, `OFS_PHASE, 8'h00);
    check("phase reset", 48'h10, q);
    bus(1'b1, 12'h100, 8'hff);
    bus(1'b0, 12'h100, 8'h00);
    check("unmapped", 48'h0, q);
    bus(1'b1, `OFS_REGULATOR, rnd);
    bus(1'b0, `OFS_REGULATOR, 8'h00);
    check("regulator", rnd, q);
    check("regulator pins", rnd, regulator_out);
    for (int i = 0; i < 12; i++) begin
        rnd = lfsr(rnd);
        bus(1'b1, `OFS_CONTROL, rnd & 8'h7f);
        bus(1'b0, `OFS_CONTROL, 8'h00);
        check("control", rnd & 8'h4f, q);
        v = lfsr(rnd);
        if (rnd[1:0] == 2'h0 || rnd[1:0] == 2'h3) v[6] = 1'b0;
        bus(1'b1, `OFS_PHASE, v);
        bus(1'b0, `OFS_PHASE, 8'h00);
        check("phase", (v & 8'hcf) | 8'h10, q);
        bus(1'b1, `OFS_SEG_BASE + 4 * (i % 6), v);
        @(posedge hclk);
        check("segment pins", v, seg_pin_enable[(i % 6) * 8 +: 8]);
        p = rnd % 24;
        bus(1'b1, `OFS_PIX_BASE + 4 * p, rnd);
        bus(1'b0, `OFS_PIX_BASE + 4 * p, 8'h00);
        check("pixel data", rnd, q);
        check("pixel map", rnd, pixel_map[pix_lo(p) +: 8]);
    end
    for (int cs = 0; cs < 4; cs++) begin
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            p = k == 0 ? 0 : (k == 1 ? 15 : rnd[3:0]);
            bus(1'b1, `OFS_CONTROL, {4'h8, cs[1:0], cs[1:0]});
            bus(1'b1, `OFS_PHASE, {4'h8, p[3:0]});
            tick_gap;
            tick_gap;
            check("frame period", gap_exp(cs, p), gap);
        end
    end
    bus(1'b1, `OFS_CONTROL, 8'hc3);
    sleep_req <= 1'b1;
    bus(1'b0, `OFS_PHASE, 8'h00);
    check("active asleep", 48'h0, q & 8'h20);
    bus(1'b1, `OFS_CONTROL, 8'h83);
    bus(1'b0, `OFS_PHASE, 8'h00);
    check("active awake", 48'h20, q & 8'h20);
    sleep_req <= 1'b0;
    bus(1'b1, `OFS_IRQ_MASK, 8'h00);
    for (int i = 0; i < 40; i++) begin
        rnd = lfsr(rnd);
        if (rnd[0]) @(posedge hclk);
        bus(1'b1, `OFS_PIX_BASE + 4 * (rnd % 24), rnd);
    end
    // corner: land a pixel write on the frame boundary cycle
    wait_edge(1'b1, 1'b1);
    repeat (gap_exp(0, p) - 2) @(posedge hclk);
    bus(1'b1, `OFS_PIX_BASE, 8'h5a);
    bus(1'b0, `OFS_CONTROL, 8'h00);
    check("write error", 48'h20, q & 8'h20);
    check("irq masked", 48'h0, irq);
    bus(1'b1, `OFS_IRQ_MASK, 8'h02);
    @(posedge hclk);
    check("irq raised", 48'h1, irq);
    bus(1'b1, `OFS_CONTROL, 8'h03);
    bus(1'b0, `OFS_CONTROL, 8'h00);
    check("error cleared", 48'h03, q);
    bus(1'b1, `OFS_IRQ_STATUS, 8'h03);
    bus(1'b0, `OFS_IRQ_STATUS, 8'h00);
    check("status cleared", 48'h0, q);
    check("irq cleared", 48'h0, irq);
    row = 48'h000000000000;
    for (int s = 0; s < 6; s++) begin
        rnd = lfsr(rnd);
        row[s * 8 +: 8] = rnd;
        bus(1'b1, `OFS_SEG_BASE + 4 * s, 8'hff);
        bus(1'b1, `OFS_PIX_BASE + 4 * s, rnd);
    end
    bus(1'b1, `OFS_CONTROL, 8'h80);
    repeat (2) @(posedge hclk);
    check("glass row", row, dark_row);
    give_verdict;
end
endmodule
